// File: pkg/prc_pkg.sv
// Package: register map, field positions and reset values of the pin route block
package prc_pkg;
   // Offsets 0x0..0x3 are not multiples of four, so they are word indices
   localparam logic [1:0]  PRC_IDX_LUT_EVT   = 2'h0;
   localparam logic [1:0]  PRC_IDX_SERIAL    = 2'h1;
   localparam logic [1:0]  PRC_IDX_WAVE      = 2'h2;
   localparam logic [1:0]  PRC_IDX_CAPTURE   = 2'h3;
   localparam int          PRC_NUM_REGS      = 4;
   localparam int          PRC_ADDR_W        = 12;
   // Writable bit masks; all other bits read zero
   localparam logic [7:0]  PRC_MASK_LUT_EVT  = 8'h37;
   localparam logic [7:0]  PRC_MASK_SERIAL   = 8'h05;
   localparam logic [7:0]  PRC_MASK_WAVE     = 8'h3F;
   localparam logic [7:0]  PRC_MASK_CAPTURE  = 8'h01;
   localparam logic [7:0]  PRC_RESET_VAL     = 8'h00;
   // Field positions
   localparam int          PRC_BIT_TABLE_ONE = 5;
   localparam int          PRC_BIT_TABLE_ZERO = 4;
   localparam int          PRC_BIT_EVT_LO    = 0;
   localparam int          PRC_BIT_SYNC_SER  = 2;
   localparam int          PRC_BIT_ASYNC_SER = 0;
   localparam int          PRC_BIT_WAVE_LO   = 0;
   localparam int          PRC_BIT_WAVE_HI   = 3;
   localparam int          PRC_BIT_CAPTURE   = 0;
   localparam int          PRC_SYNC_SER_W    = 4;
   localparam int          PRC_ASYNC_SER_W   = 3;

   typedef enum logic [1:0] {
      PRC_IDLE   = 2'b00,
      PRC_ACCESS = 2'b01
   } prc_apb_state_t;

   function automatic logic [7:0] prc_mask_of(input logic [1:0] idx);
      logic [7:0] m;
      m = PRC_MASK_CAPTURE;
      if (idx == PRC_IDX_LUT_EVT) begin
         m = PRC_MASK_LUT_EVT;
      end else if (idx == PRC_IDX_SERIAL) begin
         m = PRC_MASK_SERIAL;
      end else if (idx == PRC_IDX_WAVE) begin
         m = PRC_MASK_WAVE;
      end
      return m;
   endfunction
endpackage

// File: rtl/prc_apb_slave.sv
// APB slave holding the four route control registers
`timescale 1ns/1ps
module prc_apb_slave
   import prc_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [PRC_ADDR_W-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   output logic      [7:0]            ctrl_q [PRC_NUM_REGS]
);
   prc_apb_state_t state_q;
   // Word index; byte address is four times the index
   wire [1:0] idx      = paddr[3:2];
   wire       mapped   = (paddr[PRC_ADDR_W-1:4] == '0) && (paddr[1:0] == 2'b00);
   wire       setup    = psel && !penable && (state_q == PRC_IDLE);
   // Write lands only on the completing edge, so an abandoned setup changes nothing
   wire       done     = psel && penable && pready;
   wire       wr_ok    = done && pwrite && mapped && pstrb[0];
   wire [7:0] wr_val   = pwdata[7:0] & prc_mask_of(idx);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= PRC_IDLE;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped;
         prdata  <= (setup && !pwrite && mapped) ? {24'h00_0000, ctrl_q[idx]} : 32'h0000_0000;
         state_q <= setup ? PRC_ACCESS : PRC_IDLE;
      end
   end

   // Masked writes keep unimplemented bits at zero
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < PRC_NUM_REGS; i++) begin
            ctrl_q[i] <= PRC_RESET_VAL; // [R12]
         end
      end else if (wr_ok) begin
         ctrl_q[idx] <= wr_val; // [R12]
      end
   end
endmodule

// File: rtl/prc_pin_sel.sv
// Registered two-way pin selector: signal goes to default or alternative pin
`timescale 1ns/1ps
module prc_pin_sel
   import prc_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic         alt_sel,
   input  wire logic [W-1:0] sig_out,
   input  wire logic [W-1:0] sig_oe,
   input  wire logic [W-1:0] def_in,
   input  wire logic [W-1:0] alt_in,
   output logic      [W-1:0] def_out,
   output logic      [W-1:0] def_oe_n,
   output logic      [W-1:0] alt_out,
   output logic      [W-1:0] alt_oe_n,
   output logic      [W-1:0] sig_in
);
   // Unselected pin stays released so it cannot fight the port driver
   // Enables are active low and kept in the flop, so no gate sits after it
   wire [W-1:0] def_oe_n_d = alt_sel ? '1 : ~sig_oe;
   wire [W-1:0] alt_oe_n_d = alt_sel ? ~sig_oe : '1;
   wire [W-1:0] in_d       = alt_sel ? alt_in : def_in;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         def_out  <= '0;
         def_oe_n <= '1;
         alt_out  <= '0;
         alt_oe_n <= '1;
         sig_in   <= '0;
      end else begin
         def_out  <= sig_out;
         def_oe_n <= def_oe_n_d;
         alt_out  <= sig_out;
         alt_oe_n <= alt_oe_n_d;
         sig_in   <= in_d;
      end
   end
endmodule

// File: rtl/prc_top.sv
// Pin route control block: APB registers steering peripheral signals to package pins
`timescale 1ns/1ps
// Summary of operation
// [R1] A cleared route bit keeps a signal on its default pin or its function off, a set bit moves or enables it.
// [R2] Bit 5 of the first register moves the lookup table one output to its alternative pin.
// [R3] Bit 4 of the first register moves the lookup table zero output to its alternative pin.
// [R4] Bits 2, 1 and 0 of the first register enable event output pins 2, 1 and 0, disabled when clear.
// [R5] Bit 2 of the second register moves all synchronous serial port signals to the alternative pin set.
// [R6] Bit 0 of the second register moves all asynchronous serial port signals to the alternative pin set.
// [R7] Bits 2, 1 and 0 of the third register select alternative pins for timer waveform outputs 2, 1 and 0.
// [R8] In split mode bits 2, 1 and 0 of the third register steer the low byte compare outputs 2, 1 and 0.
// [R9] In split mode bits 5, 4 and 3 of the third register select alternative pins for waveform outputs 5, 4 and 3.
// [R10] In normal timer mode bits 5 to 3 of the third register affect no routing.
// [R11] Bit 0 of the fourth register moves the capture timer output to its alternative pin.
// [R12] All registers reset to zero and unimplemented bits read zero and ignore writes.
module prc_top
   import prc_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [PRC_ADDR_W-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [1:0]            table_out,
   output logic      [1:0]            table_def_pin,
   output logic      [1:0]            table_alt_pin,
   input  wire logic [2:0]            event_chan,
   output logic      [2:0]            event_pin,
   output logic      [2:0]            event_pin_oe_n,
   input  wire logic [PRC_SYNC_SER_W-1:0]  sync_ser_out,
   input  wire logic [PRC_SYNC_SER_W-1:0]  sync_ser_oe,
   output logic      [PRC_SYNC_SER_W-1:0]  sync_ser_in,
   input  wire logic [PRC_SYNC_SER_W-1:0]  sync_def_pin_in,
   output logic      [PRC_SYNC_SER_W-1:0]  sync_def_pin_out,
   output logic      [PRC_SYNC_SER_W-1:0]  sync_def_pin_oe_n,
   input  wire logic [PRC_SYNC_SER_W-1:0]  sync_alt_pin_in,
   output logic      [PRC_SYNC_SER_W-1:0]  sync_alt_pin_out,
   output logic      [PRC_SYNC_SER_W-1:0]  sync_alt_pin_oe_n,
   input  wire logic [PRC_ASYNC_SER_W-1:0] async_ser_out,
   input  wire logic [PRC_ASYNC_SER_W-1:0] async_ser_oe,
   output logic      [PRC_ASYNC_SER_W-1:0] async_ser_in,
   input  wire logic [PRC_ASYNC_SER_W-1:0] async_def_pin_in,
   output logic      [PRC_ASYNC_SER_W-1:0] async_def_pin_out,
   output logic      [PRC_ASYNC_SER_W-1:0] async_def_pin_oe_n,
   input  wire logic [PRC_ASYNC_SER_W-1:0] async_alt_pin_in,
   output logic      [PRC_ASYNC_SER_W-1:0] async_alt_pin_out,
   output logic      [PRC_ASYNC_SER_W-1:0] async_alt_pin_oe_n,
   input  wire logic                  wave_split_mode,
   input  wire logic [5:0]            wave_out,
   output logic      [5:0]            wave_def_pin,
   output logic      [5:0]            wave_alt_pin,
   input  wire logic                  capture_out,
   output logic                       capture_def_pin,
   output logic                       capture_alt_pin,
   output logic      [7:0]            route_lut_evt,
   output logic      [7:0]            route_serial,
   output logic      [7:0]            route_wave,
   output logic      [7:0]            route_capture
);
   logic [7:0] ctrl_q [PRC_NUM_REGS];

   prc_apb_slave u_regs (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .pstrb   (pstrb),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .ctrl_q  (ctrl_q)
   );

   wire [7:0] lut_evt_r  = ctrl_q[PRC_IDX_LUT_EVT];
   wire [7:0] serial_r   = ctrl_q[PRC_IDX_SERIAL];
   wire [7:0] wave_r     = ctrl_q[PRC_IDX_WAVE];
   wire [7:0] capture_r  = ctrl_q[PRC_IDX_CAPTURE];

   wire       table_one_alt_pin     = lut_evt_r[PRC_BIT_TABLE_ONE]; // [R2]
   wire       table_zero_alt_pin    = lut_evt_r[PRC_BIT_TABLE_ZERO]; // [R3]
   wire [2:0] event_pin_enable      = lut_evt_r[PRC_BIT_EVT_LO +: 3]; // [R4]
   wire       sync_serial_alt_pins  = serial_r[PRC_BIT_SYNC_SER]; // [R5]
   wire       async_serial_alt_pins = serial_r[PRC_BIT_ASYNC_SER]; // [R6]
   wire       capture_timer_alt_pin = capture_r[PRC_BIT_CAPTURE]; // [R11]
   // Low three bits act in both modes; in split mode they carry low byte compares
   wire [2:0] wave_lo_alt = wave_r[PRC_BIT_WAVE_LO +: 3]; // [R7] [R8]
   // Upper outputs exist only in split mode, so their bits are ignored otherwise
   wire [2:0] wave_hi_alt = wave_split_mode ? wave_r[PRC_BIT_WAVE_HI +: 3] : 3'h0; // [R9] [R10]
   wire [5:0] wave_alt    = {wave_hi_alt, wave_lo_alt};
   wire [5:0] wave_live   = wave_split_mode ? wave_out : {3'h0, wave_out[2:0]}; // [R10]
   wire [1:0] table_alt   = {table_one_alt_pin, table_zero_alt_pin};

   prc_pin_sel #(.W(PRC_SYNC_SER_W)) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .alt_sel (sync_serial_alt_pins), // [R5]
      .sig_out (sync_ser_out),
      .sig_oe  (sync_ser_oe),
      .def_in  (sync_def_pin_in),
      .alt_in  (sync_alt_pin_in),
      .def_out  (sync_def_pin_out),
      .def_oe_n (sync_def_pin_oe_n),
      .alt_out  (sync_alt_pin_out),
      .alt_oe_n (sync_alt_pin_oe_n),
      .sig_in  (sync_ser_in)
   );

   prc_pin_sel #(.W(PRC_ASYNC_SER_W)) u_async (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .alt_sel (async_serial_alt_pins), // [R6]
      .sig_out (async_ser_out),
      .sig_oe  (async_ser_oe),
      .def_in  (async_def_pin_in),
      .alt_in  (async_alt_pin_in),
      .def_out  (async_def_pin_out),
      .def_oe_n (async_def_pin_oe_n),
      .alt_out  (async_alt_pin_out),
      .alt_oe_n (async_alt_pin_oe_n),
      .sig_in   (async_ser_in)
   );

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         table_def_pin   <= 2'h0;
         table_alt_pin   <= 2'h0;
         event_pin       <= 3'h0;
         event_pin_oe_n  <= 3'h7;
         wave_def_pin    <= 6'h00;
         wave_alt_pin    <= 6'h00;
         capture_def_pin <= 1'b0;
         capture_alt_pin <= 1'b0;
      end else begin
         table_def_pin   <= table_out & ~table_alt; // [R1] [R2] [R3]
         table_alt_pin   <= table_out & table_alt; // [R2] [R3]
         event_pin       <= event_chan & event_pin_enable; // [R4]
         event_pin_oe_n  <= ~event_pin_enable; // [R1] [R4]
         wave_def_pin    <= wave_live & ~wave_alt; // [R7] [R9]
         wave_alt_pin    <= wave_live & wave_alt; // [R7] [R8] [R9]
         capture_def_pin <= capture_out & ~capture_timer_alt_pin; // [R11]
         capture_alt_pin <= capture_out & capture_timer_alt_pin; // [R11]
      end
   end

   // Register copies for other blocks, taken from flip-flops
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         route_lut_evt <= PRC_RESET_VAL;
         route_serial  <= PRC_RESET_VAL;
         route_wave    <= PRC_RESET_VAL;
         route_capture <= PRC_RESET_VAL;
      end else begin
         route_lut_evt <= lut_evt_r;
         route_serial  <= serial_r;
         route_wave    <= wave_r;
         route_capture <= capture_r;
      end
   end
endmodule

// File: tb/prc_monitor.sv
// Concurrent checks on the pin route block ports
`timescale 1ns/1ps
module prc_monitor
   import prc_pkg::*;
(
   input wire logic                  clk_sys, rst_n, psel, penable, pready, pwrite, wave_split_mode,
   input wire logic                  capture_out, capture_alt_pin,
   input wire logic [PRC_ADDR_W-1:0] paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [3:0]            pstrb, sync_ser_oe, sync_alt_pin_oe_n,
   input wire logic [1:0]            table_out, table_alt_pin,
   input wire logic [2:0]            event_chan, event_pin, event_pin_oe_n, async_ser_oe, async_alt_pin_oe_n,
   input wire logic [5:0]            wave_out, wave_def_pin, wave_alt_pin,
   input wire logic [7:0]            route_lut_evt, route_serial, route_wave, route_capture
);
   default clocking mon_cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   sequence lut_wr_s;
      psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h000;
   endsequence
   sequence lut_seen_s;
      ##2 route_lut_evt == ($past(pwdata[7:0], 2) & PRC_MASK_LUT_EVT);
   endsequence
   reg_write_a: assert property (lut_wr_s |-> lut_seen_s)
      else $error("route register write not seen");
   unused_bits_a: assert property (((route_lut_evt & ~PRC_MASK_LUT_EVT) | (route_serial & ~PRC_MASK_SERIAL)
      | (route_wave & ~PRC_MASK_WAVE) | (route_capture & ~PRC_MASK_CAPTURE)) == 8'h00)
      else $error("unimplemented route bit set");
   lut_route_a: assert property (table_alt_pin == ($past(table_out) & route_lut_evt[5:4]))
      else $error("table alternative pin wrong");
   event_enable_a: assert property (event_pin_oe_n == ~route_lut_evt[2:0]
      && event_pin == ($past(event_chan) & route_lut_evt[2:0]))
      else $error("event pin enable wrong");
   sync_pins_a: assert property (sync_alt_pin_oe_n == (route_serial[2] ? ~$past(sync_ser_oe) : 4'hF))
      else $error("sync serial alternative enables wrong");
   async_pins_a: assert property (async_alt_pin_oe_n == (route_serial[0] ? ~$past(async_ser_oe) : 3'h7))
      else $error("async serial alternative enables wrong");
   wave_low_a: assert property (wave_alt_pin[2:0] == ($past(wave_out[2:0]) & route_wave[2:0]))
      else $error("low waveform alternative pin wrong");
   wave_split_a: assert property ($past(wave_split_mode) |-> wave_alt_pin[5:3] == ($past(wave_out[5:3]) & route_wave[5:3]))
      else $error("split waveform alternative pin wrong");
   wave_normal_a: assert property (!$past(wave_split_mode) |-> wave_alt_pin[5:3] == 3'h0 && wave_def_pin[5:3] == 3'h0)
      else $error("upper waveform routed in normal mode");
   capture_alt_a: assert property (capture_alt_pin == ($past(capture_out) & route_capture[0]))
      else $error("capture alternative pin wrong");
endmodule
bind prc_top prc_monitor u_prc_monitor (.*);

// File: tb/prc_pad_model.sv
// Pad model of the package pins as seen from the far side
`timescale 1ns/1ps
module prc_pad_model
   import prc_pkg::*;
#(
   parameter int W = 4
) (
   input  wire logic [W-1:0] pin_out,
   input  wire logic [W-1:0] pin_oe_n,
   input  wire logic [W-1:0] ext_lvl,
   output logic      [W-1:0] pin_in
);
   // Undriven pads follow the outside driver, which the bench keeps changing so no stale level hides
   assign pin_in = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
endmodule

// File: tb/test_peripheral_pin_route_control.sv
// Self-checking bench for the pin route block
`timescale 1ns/1ps
module test_peripheral_pin_route_control;
   import prc_pkg::*;
   logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, wave_split_mode, capture_out, capture_def_pin, capture_alt_pin;
   logic [PRC_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb, sync_ser_out, sync_ser_oe, sync_ser_in, sync_def_pin_in, sync_def_pin_out, sync_def_pin_oe_n;
   logic [3:0]  sync_alt_pin_in, sync_alt_pin_out, sync_alt_pin_oe_n, sext_d, sext_a;
   logic [2:0]  async_ser_out, async_ser_oe, async_ser_in, async_def_pin_in, async_def_pin_out, async_def_pin_oe_n;
   logic [2:0]  async_alt_pin_in, async_alt_pin_out, async_alt_pin_oe_n, aext_d, aext_a, event_chan, event_pin, event_pin_oe_n;
   logic [1:0]  table_out, table_def_pin, table_alt_pin;
   logic [5:0]  wave_out, wave_def_pin, wave_alt_pin;
   logic [7:0]  route_lut_evt, route_serial, route_wave, route_capture;
   logic [7:0]  regs [4];
   int          fail_count = 0;
   int          check_count = 0;
   prc_top dut (.*);
   prc_pad_model #(.W(4)) u_sd (.pin_out(sync_def_pin_out), .pin_oe_n(sync_def_pin_oe_n), .ext_lvl(sext_d), .pin_in(sync_def_pin_in));
   prc_pad_model #(.W(4)) u_sa (.pin_out(sync_alt_pin_out), .pin_oe_n(sync_alt_pin_oe_n), .ext_lvl(sext_a), .pin_in(sync_alt_pin_in));
   prc_pad_model #(.W(3)) u_ad (.pin_out(async_def_pin_out), .pin_oe_n(async_def_pin_oe_n), .ext_lvl(aext_d), .pin_in(async_def_pin_in));
   prc_pad_model #(.W(3)) u_aa (.pin_out(async_alt_pin_out), .pin_oe_n(async_alt_pin_oe_n), .ext_lvl(aext_a), .pin_in(async_alt_pin_in));
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask
   // Pin in from the selected set: own drive where enabled, far side elsewhere
   function automatic logic [3:0] ser_in(input logic alt, input logic [3:0] o, oe, d, a);
      return (o & oe) | ((alt ? a : d) & ~oe);
   endfunction
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge clk_sys);
      penable <= 1'b1;
      // Request held until pready is seen high at a rising edge; data taken there
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 16);
      chk("pready_wait", 32'h0, {31'h0, pready !== 1'b1});
      rdata = prdata;
      chk("pslverr", {31'h0, addr[4]}, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      end_sim();
   end
   initial begin
      logic [31:0] rd;
      logic [31:0] wd;
      logic [7:0]  mtbl [4];
      logic [2:0]  hi;
      mtbl = '{PRC_MASK_LUT_EVT, PRC_MASK_SERIAL, PRC_MASK_WAVE, PRC_MASK_CAPTURE};
      {psel, penable, pwrite, paddr, pwdata, table_out, event_chan, wave_split_mode, capture_out} = '0;
      {sync_ser_out, sync_ser_oe, async_ser_out, async_ser_oe, wave_out, sext_d, sext_a, aext_d, aext_a} = '0;
      pstrb = 4'hF;
      rst_n = 1'b0;
      void'($urandom(32'h9DD01E80));
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int r = 0; r < 4; r++) begin
         apb(1'b0, 12'(r * 4), 32'h0, rd);
         chk("reset_value", 32'h0, rd);
      end
      apb(1'b0, 12'h010, 32'h0, rd);
      chk("unmapped_rdata", 32'h0, rd);
      for (int t = 0; t < 48; t++) begin
         for (int r = 0; r < 4; r++) begin
            wd = $urandom();
            if (t < 2) wd[7:0] = {8{t[0]}};
            regs[r] = wd[7:0] & mtbl[r];
            apb(1'b1, 12'(r * 4), wd, rd);
            apb(1'b0, 12'(r * 4), 32'h0, rd);
            chk("readback", {24'h0, regs[r]}, rd);
         end
         @(posedge clk_sys);
         {table_out, event_chan, sync_ser_out, sync_ser_oe, async_ser_out, async_ser_oe, wave_out, capture_out} <= 26'($urandom());
         {sext_d, sext_a, aext_d, aext_a} <= 14'($urandom());
         wave_split_mode <= (t < 4) ? t[1] : 1'($urandom());
         repeat (4) @(posedge clk_sys);
         @(negedge clk_sys);
         hi = wave_split_mode ? 3'h7 : 3'h0;
         chk("table_alt_pin", table_out & regs[0][5:4], table_alt_pin);
         chk("table_def_pin", table_out & ~regs[0][5:4], table_def_pin);
         chk("event_pin", event_chan & regs[0][2:0], event_pin);
         chk("event_pin_oe_n", regs[0][2:0] ^ 3'h7, event_pin_oe_n);
         chk("sync_ser_in", ser_in(regs[1][2], sync_ser_out, sync_ser_oe, sext_d, sext_a), sync_ser_in);
         chk("sync_def_pin_oe_n", regs[1][2] ? 4'hF : sync_ser_oe ^ 4'hF, sync_def_pin_oe_n);
         chk("sync_alt_pin_oe_n", regs[1][2] ? sync_ser_oe ^ 4'hF : 4'hF, sync_alt_pin_oe_n);
         chk("sync_pin_out", {sync_ser_out, sync_ser_out}, {sync_def_pin_out, sync_alt_pin_out});
         chk("async_ser_in", ser_in(regs[1][0], {1'b0, async_ser_out}, {1'b0, async_ser_oe}, {1'b0, aext_d},
            {1'b0, aext_a}), {1'b0, async_ser_in});
         chk("async_def_pin_oe_n", regs[1][0] ? 3'h7 : async_ser_oe ^ 3'h7, async_def_pin_oe_n);
         chk("async_alt_pin_oe_n", regs[1][0] ? async_ser_oe ^ 3'h7 : 3'h7, async_alt_pin_oe_n);
         chk("async_pin_out", {async_ser_out, async_ser_out}, {async_def_pin_out, async_alt_pin_out});
         chk("wave_alt_pin", wave_out & regs[2][5:0] & {hi, 3'h7}, wave_alt_pin);
         chk("wave_def_pin", wave_out & ~regs[2][5:0] & {hi, 3'h7}, wave_def_pin);
         chk("capture_alt_pin", capture_out & regs[3][0], capture_alt_pin);
         chk("capture_def_pin", capture_out & ~regs[3][0], capture_def_pin);
         chk("route_copies", {regs[0], regs[1], regs[2], regs[3]},
            {route_lut_evt, route_serial, route_wave, route_capture});
      end
      // Second reset in mid-run with live inputs: every register must clear again
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int r = 0; r < 4; r++) begin
         apb(1'b0, 12'(r * 4), 32'h0, rd);
         chk("reset_again", 32'h0, rd);
      end
      @(negedge clk_sys);
      chk("event_pin_oe_n_reset", 3'h7, event_pin_oe_n);
      chk("table_alt_pin_reset", 2'h0, table_alt_pin);
      end_sim();
   end
endmodule
